// ===== design/servo_cmd_cfg.svh
// offsets, field positions, reset values and counts for the servo command interpreter
`ifndef SERVO_CMD_CFG_SVH
`define SERVO_CMD_CFG_SVH
`define OFF_CMD          8'h00
`define OFF_ARG          8'h04
`define OFF_MASK         8'h08
`define OFF_STATE        8'h0C
`define OFF_CUR_POS      8'h10
`define OFF_TGT_POS      8'h14
`define OFF_POS_ERR      8'h18
`define OFF_SPEED_MON    8'h1C
`define OFF_ORIGIN_SW    8'h20
`define OFF_OUT_STATUS   8'h24
`define OFF_SET_SPEED    8'h28
`define OFF_ORIGIN_POS   8'h2C
`define OFF_CMD_SPEED    8'h30
`define MASK_RESET       8'h00
`define MASK_ALL         8'hFF
`define MB_SERVO_ON      0
`define MB_FWD_INHIBIT   1
`define MB_REV_INHIBIT   2
`define MB_BRAKE         5
`define MB_ALARM_CLEAR   6
`define MB_INHIBIT       7
`define OS_READY         0
`define OS_IN_POS        1
`define OS_ALARM_A       2
`define OS_ALARM_B       3
`define OS_ALARM_C       4
`define SET_SPEED_RESET  32'h0000_000A
`define ORIGIN_RESET     32'h0000_0000
`define POS_ZERO         32'h0000_0000
`define RESTART_CYCLES   16
`endif

// ===== design/servo_cmd_pkg.sv
// types shared by the servo command interpreter
package servo_cmd_pkg;
    typedef enum logic [3:0] {
        CMD_NONE, CMD_MASK_ALL, CMD_SERVO_ON, CMD_SERVO_OFF, CMD_BRAKE_ON, CMD_BRAKE_OFF,
        CMD_FREE, CMD_GO, CMD_HALT, CMD_ALARM_RESET, CMD_RESTART, CMD_POS_TARGET,
        CMD_SPEED, CMD_PRESET, CMD_ADOPT, CMD_CLEAR
    } cmd_e;
    typedef enum logic [4:0] {
        OP_NONE   = 5'h00,
        OP_ECLEAR = 5'h10
    } op_t_unused_e;
    typedef struct packed {
        logic       servo_on;
        logic       brake_on;
        logic       halted;
        logic       restarting;
        logic       alarm;
        logic       reverse;
    } drive_state_s;
endpackage : servo_cmd_pkg

// ===== design/servo_command_interpreter.sv
// servo command interpreter with a classic wishbone register slave
// Contract
// - mask-all command sets all eight input-ignore bits, same as writing 255.
// - servo on/off commands act like the connector input, only with brake released.
// - brake-on command engages the dynamic brake like the connector input.
// - brake-off releases brake, motor free; host must send servo-on again.
// - free command frees the motor always, whatever the brake state.
// - halt stops motion in every mode, keeping mode and target.
// - go resumes halted motion and accepts motion commands again.
// - alarm reset clears alarm and position error, only when alarm pending.
// - restart performs a near power-cycle restart of the drive state.
// - position target starts a move using last speed or setting speed.
// - unsigned target rotates forward, negative target rotates reverse.
// - speed command sets movement speed in r/min, applied smoothly.
// - origin preset loads origin position into current and target.
// - adopt-current copies current position into target register.
// - clear writes zero to current position and target.
// - error-preserving clear zeroes target, current keeps retained error.
// - positions are held in a 32-bit range.
// - current-position query returns the current position count.
// - speed query returns filtered present speed in r/min.
// - position-error query returns the present position error.
// - origin-switch query returns 1 when switch on, 0 when off.
// - output status: bit0 ready, bit1 in position, bits2-4 alarm lines.
// - input-ignore mask resets to zero; set bits give serial priority.
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "servo_cmd_cfg.svh"
module servo_command_interpreter
    import servo_cmd_pkg::*;
#(
    parameter int POS_W = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    input  wire logic [7:0]       connector_in_i,
    input  wire logic [POS_W-1:0] actual_pos_i,
    input  wire logic             actual_pos_valid_i,
    input  wire logic [31:0]      filtered_speed_i,
    input  wire logic             origin_switch_i,
    input  wire logic             alarm_pending_i,
    input  wire logic [2:0]       alarm_lines_i,
    input  wire logic             in_position_i,
    output logic      [7:0]       input_ignore_mask_o,
    output logic                  servo_enable_o,
    output logic                  brake_engage_o,
    output logic                  motor_free_o,
    output logic                  motion_halt_o,
    output logic                  alarm_clear_o,
    output logic                  error_clear_o,
    output logic                  restart_o,
    output logic                  move_start_o,
    output logic                  move_reverse_o,
    output logic      [POS_W-1:0] target_pos_o,
    output logic      [31:0]      move_speed_o,
    output logic                  pos_load_o,
    output logic      [POS_W-1:0] pos_load_value_o
);

    // bus access decode; ack is a single registered pulse
    logic             req;
    logic             wr;
    logic             ack_reg;
    logic             ack_next;
    logic [31:0]      rdat_reg;
    logic [31:0]      rdat_next;
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr  = req & wb_we_i & (&wb_sel_i);

    // control and position state
    logic [7:0]       mask_reg;
    logic [7:0]       mask_next;
    logic [31:0]      arg_reg;
    logic [31:0]      arg_next;
    logic [31:0]      set_speed_reg;
    logic [31:0]      set_speed_next;
    logic [31:0]      cmd_speed_reg;
    logic [31:0]      cmd_speed_next;
    logic             speed_given_reg;
    logic             speed_given_next;
    logic [POS_W-1:0] origin_reg;
    logic [POS_W-1:0] origin_next;
    logic [POS_W-1:0] cur_reg;
    logic [POS_W-1:0] cur_next;
    logic [POS_W-1:0] tgt_reg;
    logic [POS_W-1:0] tgt_next;
    logic [POS_W-1:0] err;
    drive_state_s     st_reg;
    drive_state_s     st_next;
    logic [4:0]       rst_cnt_reg;
    logic [4:0]       rst_cnt_next;
    logic             eff_servo_enable_cmd;
    logic             eff_brake;
    cmd_e             cmd;

    // pulse outputs registered so every pulse output comes from a flip-flop
    logic             alarm_clr_reg;
    logic             alarm_clr_next;
    logic             err_clr_reg;
    logic             err_clr_next;
    logic             move_reg;
    logic             move_next;
    logic             load_reg;
    logic             load_next;
    logic [POS_W-1:0] load_val_reg;
    logic [POS_W-1:0] load_val_next;

    assign cmd = cmd_e'(wb_dat_i[3:0]);
    assign err = tgt_reg - cur_reg;

    // connector inputs win unless their ignore bit is set
    // serial priority
    assign eff_servo_enable_cmd  = mask_reg[`MB_SERVO_ON] ? st_reg.servo_on : connector_in_i[`MB_SERVO_ON];
    assign eff_brake = mask_reg[`MB_BRAKE]    ? st_reg.brake_on : connector_in_i[`MB_BRAKE];

    // command execution and register writes
    always_comb begin
        mask_next        = mask_reg;
        arg_next         = arg_reg;
        set_speed_next   = set_speed_reg;
        cmd_speed_next   = cmd_speed_reg;
        speed_given_next = speed_given_reg;
        origin_next      = origin_reg;
        cur_next         = actual_pos_valid_i ? actual_pos_i : cur_reg;
        tgt_next         = tgt_reg;
        st_next          = st_reg;
        st_next.alarm    = alarm_pending_i;
        rst_cnt_next     = rst_cnt_reg;
        alarm_clr_next   = 1'b0;
        err_clr_next     = 1'b0;
        move_next        = 1'b0;
        load_next        = 1'b0;
        load_val_next    = load_val_reg;
        if (st_reg.restarting) begin
            if (rst_cnt_reg == 5'(`RESTART_CYCLES)) begin
                st_next.restarting = 1'b0;
            end else begin
                rst_cnt_next = rst_cnt_reg + 5'd1;
            end
        end
        if (wr && !st_reg.restarting) begin
            case (wb_adr_i)
                `OFF_MASK: begin
                    mask_next = wb_dat_i[7:0];
                end
                `OFF_ARG: begin
                    arg_next = wb_dat_i;
                end
                `OFF_SET_SPEED: begin
                    set_speed_next = wb_dat_i;
                end
                `OFF_ORIGIN_POS: begin
                    origin_next = wb_dat_i[POS_W-1:0];
                end
                `OFF_CMD: begin
                    case (cmd)
                        CMD_MASK_ALL: mask_next = `MASK_ALL;
                        CMD_SERVO_ON: if (!eff_brake) st_next.servo_on = 1'b1;
                        CMD_SERVO_OFF: if (!eff_brake) st_next.servo_on = 1'b0;
                        CMD_BRAKE_ON: st_next.brake_on = 1'b1;
                        CMD_BRAKE_OFF: begin
                            st_next.brake_on = 1'b0;
                            st_next.servo_on = 1'b0;
                        end
                        CMD_FREE: st_next.servo_on = 1'b0;
                        CMD_GO: st_next.halted = 1'b0;
                        CMD_HALT: st_next.halted = 1'b1;
                        CMD_ALARM_RESET: begin
                            if (alarm_pending_i) begin
                                alarm_clr_next = 1'b1;
                                err_clr_next   = 1'b1;
                                tgt_next       = cur_next;
                            end
                        end
                        CMD_RESTART: begin
                            st_next          = '0;
                            st_next.restarting = 1'b1;
                            rst_cnt_next     = 5'd0;
                            mask_next        = `MASK_RESET;
                            speed_given_next = 1'b0;
                        end
                        CMD_POS_TARGET: begin
                            if (!st_reg.halted) begin
                                tgt_next  = arg_reg[POS_W-1:0];
                                st_next.reverse = arg_reg[31];
                                move_next = 1'b1;
                            end
                        end
                        CMD_SPEED: begin
                            cmd_speed_next   = arg_reg;
                            speed_given_next = 1'b1;
                        end
                        CMD_PRESET: begin
                            cur_next      = origin_reg;
                            tgt_next      = origin_reg;
                            load_next     = 1'b1;
                            load_val_next = origin_reg;
                        end
                        CMD_ADOPT: tgt_next = cur_next;
                        CMD_CLEAR: begin
                            cur_next      = `POS_ZERO;
                            tgt_next      = `POS_ZERO;
                            load_next     = 1'b1;
                            load_val_next = `POS_ZERO;
                        end
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
        // keep error, zero target
        // only with command code zero, so bit 4 of another command never clears positions
        if (wr && !st_reg.restarting && wb_adr_i == `OFF_CMD && cmd == CMD_NONE
                && wb_dat_i[4]) begin
            tgt_next      = `POS_ZERO;
            cur_next      = cur_reg - tgt_reg;
            load_next     = 1'b1;
            load_val_next = cur_reg - tgt_reg;
        end
    end

    // read mux; unmapped reads return zero
    always_comb begin
        ack_next  = req;
        rdat_next = 32'h0000_0000;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                `OFF_ARG:        rdat_next = arg_reg;
                `OFF_MASK:       rdat_next = {24'h00_0000, mask_reg};
                `OFF_STATE:      rdat_next = {26'h000_0000, st_reg};
                `OFF_CUR_POS:    rdat_next = 32'(cur_reg);
                `OFF_TGT_POS:    rdat_next = 32'(tgt_reg);
                `OFF_POS_ERR:    rdat_next = 32'(err);
                `OFF_SPEED_MON:  rdat_next = filtered_speed_i;
                `OFF_ORIGIN_SW:  rdat_next = {31'h0000_0000, origin_switch_i};
                `OFF_OUT_STATUS: rdat_next = {27'h000_0000, alarm_lines_i,
                                              in_position_i, eff_servo_enable_cmd & ~alarm_pending_i};
                `OFF_SET_SPEED:  rdat_next = set_speed_reg;
                `OFF_ORIGIN_POS: rdat_next = 32'(origin_reg);
                `OFF_CMD_SPEED:  rdat_next = cmd_speed_reg;
                default:         rdat_next = 32'h0000_0000;
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg         <= 1'b0;
            rdat_reg        <= 32'h0000_0000;
            mask_reg        <= `MASK_RESET;
            arg_reg         <= 32'h0000_0000;
            set_speed_reg   <= `SET_SPEED_RESET;
            cmd_speed_reg   <= 32'h0000_0000;
            speed_given_reg <= 1'b0;
            origin_reg      <= `ORIGIN_RESET;
            cur_reg         <= '0;
            tgt_reg         <= '0;
            st_reg          <= '0;
            rst_cnt_reg     <= 5'd0;
            alarm_clr_reg   <= 1'b0;
            err_clr_reg     <= 1'b0;
            move_reg        <= 1'b0;
            load_reg        <= 1'b0;
            load_val_reg    <= '0;
        end else begin
            ack_reg         <= ack_next;
            rdat_reg        <= rdat_next;
            mask_reg        <= mask_next;
            arg_reg         <= arg_next;
            set_speed_reg   <= set_speed_next;
            cmd_speed_reg   <= cmd_speed_next;
            speed_given_reg <= speed_given_next;
            origin_reg      <= origin_next;
            cur_reg         <= cur_next;
            tgt_reg         <= tgt_next;
            st_reg          <= st_next;
            rst_cnt_reg     <= rst_cnt_next;
            alarm_clr_reg   <= alarm_clr_next;
            err_clr_reg     <= err_clr_next;
            move_reg        <= move_next;
            load_reg        <= load_next;
            load_val_reg    <= load_val_next;
        end
    end

    // outputs from flip-flops; motor_free_o inverts one and move_speed_o selects between two
    assign wb_ack_o            = ack_reg;
    assign wb_dat_o            = rdat_reg;
    assign input_ignore_mask_o = mask_reg;
    assign servo_enable_o      = st_reg.servo_on;
    assign brake_engage_o      = st_reg.brake_on;
    assign motor_free_o        = ~st_reg.servo_on;
    assign motion_halt_o       = st_reg.halted;
    assign restart_o           = st_reg.restarting;
    assign alarm_clear_o       = alarm_clr_reg;
    assign error_clear_o       = err_clr_reg;
    assign move_start_o        = move_reg;
    assign move_reverse_o      = st_reg.reverse;
    assign target_pos_o        = tgt_reg;
    assign move_speed_o        = speed_given_reg ? cmd_speed_reg : set_speed_reg;
    assign pos_load_o          = load_reg;
    assign pos_load_value_o    = load_val_reg;

endmodule : servo_command_interpreter

// ===== testbench/servo_cmd_checker_assertions.sv
// concurrent checks on the ports of the servo command interpreter
`timescale 1ns/1ps
`include "servo_cmd_cfg.svh"
module servo_cmd_checker
    import servo_cmd_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic             clk_i,
    input wire logic             rst_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [7:0]       wb_adr_i,
    input wire logic [3:0]       wb_sel_i,
    input wire logic [31:0]      wb_dat_i,
    input wire logic             wb_ack_o,
    input wire logic             alarm_pending_i,
    input wire logic [7:0]       input_ignore_mask_o,
    input wire logic             brake_engage_o,
    input wire logic             motor_free_o,
    input wire logic             motion_halt_o,
    input wire logic             alarm_clear_o,
    input wire logic             error_clear_o,
    input wire logic             restart_o,
    input wire logic             pos_load_o,
    input wire logic [POS_W-1:0] target_pos_o,
    input wire logic [POS_W-1:0] pos_load_value_o
);
    // a command write taken at this edge; restart windows drop writes, so they are excluded
    logic       cmd_wr;
    logic [3:0] cmd_code;
    assign cmd_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hF
                    && wb_adr_i == `OFF_CMD && !restart_o;
    assign cmd_code = wb_dat_i[3:0];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_mask_reset: assert property (
        disable iff (1'b0) rst_i |=> input_ignore_mask_o == `MASK_RESET) else $error("mask reset");
    chk_mask_all: assert property (
        cmd_wr && cmd_code == 4'h1 |=> input_ignore_mask_o == `MASK_ALL) else $error("mask all");
    chk_brake_on: assert property (
        cmd_wr && cmd_code == 4'h4 && input_ignore_mask_o[`MB_BRAKE] |=> brake_engage_o)
        else $error("brake not engaged");
    chk_free_always: assert property (
        cmd_wr && cmd_code == 4'h6 && input_ignore_mask_o[`MB_SERVO_ON] |=> motor_free_o)
        else $error("motor not freed");
    chk_halt_keeps: assert property (
        cmd_wr && cmd_code == 4'h8 |=> motion_halt_o && $stable(target_pos_o))
        else $error("halt wrong");
    chk_go_resumes: assert property (
        cmd_wr && cmd_code == 4'h7 |=> !motion_halt_o) else $error("go wrong");
    chk_alarm_reset: assert property (
        cmd_wr && cmd_code == 4'h9 |=> alarm_clear_o == $past(alarm_pending_i)
        && error_clear_o == $past(alarm_pending_i)) else $error("alarm reset wrong");
    chk_clear_zero: assert property (
        cmd_wr && cmd_code == 4'hF |=> pos_load_o && pos_load_value_o == '0
        && target_pos_o == '0) else $error("clear wrong");
    chk_eclear_target: assert property (
        cmd_wr && cmd_code == 4'h0 && wb_dat_i[4] |=> target_pos_o == '0)
        else $error("error keeping clear wrong");
endmodule : servo_cmd_checker

bind servo_command_interpreter servo_cmd_checker #(.POS_W(POS_W)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .alarm_pending_i(alarm_pending_i), .input_ignore_mask_o(input_ignore_mask_o),
    .brake_engage_o(brake_engage_o), .motor_free_o(motor_free_o),
    .motion_halt_o(motion_halt_o), .alarm_clear_o(alarm_clear_o),
    .error_clear_o(error_clear_o), .restart_o(restart_o), .pos_load_o(pos_load_o),
    .target_pos_o(target_pos_o), .pos_load_value_o(pos_load_value_o));

// ===== testbench/servo_plant_model.sv
// behavioural drive plant that feeds the measured position back
`timescale 1ns/1ps
module servo_plant_model #(
    parameter int POS_W = 32
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             step_i,
    input  wire logic [POS_W-1:0] delta_i,
    input  wire logic             pos_load_i,
    input  wire logic [POS_W-1:0] pos_load_value_i,
    output logic      [POS_W-1:0] actual_pos_o,
    output logic                  actual_pos_valid_o
);
    // a counter reload wins over motion, so a preset never races a step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            actual_pos_o       <= '0;
            actual_pos_valid_o <= 1'b0;
        end else begin
            actual_pos_valid_o <= step_i;
            if (pos_load_i) begin
                actual_pos_o <= pos_load_value_i;
            end else if (step_i) begin
                actual_pos_o <= actual_pos_o + delta_i;
            end
        end
    end
endmodule : servo_plant_model

// ===== testbench/servo_command_interpreter_tb.sv
// self-checking bench for the servo command interpreter
`timescale 1ns/1ps
`include "servo_cmd_cfg.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module servo_command_interpreter_tb
    import servo_cmd_pkg::*;
;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, step;
    logic        origin_switch_i, alarm_pending_i, in_position_i, actual_pos_valid_i;
    logic        servo_enable_o, brake_engage_o, motor_free_o, motion_halt_o, restart_o;
    logic        alarm_clear_o, error_clear_o, move_start_o, move_reverse_o, pos_load_o;
    logic [7:0]  wb_adr_i, connector_in_i, input_ignore_mask_o;
    logic [3:0]  wb_sel_i, pl;
    logic [2:0]  alarm_lines_i;
    logic [31:0] wb_dat_i, wb_dat_o, filtered_speed_i, actual_pos_i, target_pos_o;
    logic [31:0] move_speed_o, pos_load_value_o, delta, rd, a, b, e;
    int          failures, compares, n;

    servo_command_interpreter uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .connector_in_i(connector_in_i), .actual_pos_i(actual_pos_i),
        .actual_pos_valid_i(actual_pos_valid_i), .filtered_speed_i(filtered_speed_i),
        .origin_switch_i(origin_switch_i), .alarm_pending_i(alarm_pending_i),
        .alarm_lines_i(alarm_lines_i), .in_position_i(in_position_i),
        .input_ignore_mask_o(input_ignore_mask_o), .servo_enable_o(servo_enable_o),
        .brake_engage_o(brake_engage_o), .motor_free_o(motor_free_o),
        .motion_halt_o(motion_halt_o), .alarm_clear_o(alarm_clear_o),
        .error_clear_o(error_clear_o), .restart_o(restart_o), .move_start_o(move_start_o),
        .move_reverse_o(move_reverse_o), .target_pos_o(target_pos_o),
        .move_speed_o(move_speed_o), .pos_load_o(pos_load_o),
        .pos_load_value_o(pos_load_value_o));
    servo_plant_model plant (.clk_i(clk_i), .rst_i(rst_i), .step_i(step), .delta_i(delta),
        .pos_load_i(pos_load_o), .pos_load_value_i(pos_load_value_o),
        .actual_pos_o(actual_pos_i), .actual_pos_valid_o(actual_pos_valid_i));

    // clock at 40 MHz
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // one classic cycle; everything is taken at the edge that samples ack high
    task wbx(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= ad; wb_dat_i <= d;
        k = 0;
        do begin @(posedge clk_i); k++; end while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50) failures++;
        rd = wb_dat_o;
        pl = {alarm_clear_o, error_clear_o, move_start_o, pos_load_o};
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    endtask : wbx

    task cmd(input logic [31:0] c);
        wbx(1'b1, `OFF_CMD, c);
    endtask : cmd

    // one plant move, then time for the position feed to be captured
    task stepit(input logic [31:0] d);
        delta <= d; step <= 1'b1;
        @(posedge clk_i);
        step <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask : stepit

    function automatic logic [31:0] status_exp(input logic srv, alm, ip, input logic [2:0] al);
        return {27'h000_0000, al, ip, srv & !alm};
    endfunction : status_exp

    task results();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results

    // watchdog sized well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        results();
    end

    initial begin
        rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_adr_i = 8'h00;
        wb_sel_i = 4'hF; wb_dat_i = 32'h0000_0000; connector_in_i = 8'h00; step = 1'b0;
        delta = 32'h0000_0000; filtered_speed_i = 32'h0000_0000; origin_switch_i = 1'b0;
        alarm_pending_i = 1'b0; alarm_lines_i = 3'h0; in_position_i = 1'b0;
        failures = 0; compares = 0;
        n = $urandom(32'he2e5_f971);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wbx(1'b0, `OFF_MASK, 32'h0000_0000);
        `CHK("mask after reset", 32'h0000_0000, rd)
        wbx(1'b1, `OFF_MASK, {24'h00_0000, 8'($urandom)});
        cmd(32'h0000_0001);
        wbx(1'b0, `OFF_MASK, 32'h0000_0000);
        `CHK("mask all", 32'h0000_00FF, rd)
        connector_in_i <= 8'($urandom);
        cmd(32'h0000_0004);
        `CHK("brake on", 1'b1, brake_engage_o)
        cmd(32'h0000_0002);
        `CHK("servo under brake", 1'b0, servo_enable_o)
        cmd(32'h0000_0005);
        `CHK("brake off", 2'b00, {brake_engage_o, servo_enable_o})
        cmd(32'h0000_0002);
        `CHK("servo on", 1'b1, servo_enable_o)
        cmd(32'h0000_0006);
        `CHK("free", 1'b1, motor_free_o)
        cmd(32'h0000_0002);
        cmd(32'h0000_0003);
        `CHK("servo off", 1'b0, servo_enable_o)
        cmd(32'h0000_0002);
        a = $urandom & 32'h7FFF_FFFF;
        wbx(1'b1, `OFF_ARG, a);
        cmd(32'h0000_000B);
        `CHK("move start", 1'b1, pl[1])
        `CHK("target", a, target_pos_o)
        `CHK("forward", 1'b0, move_reverse_o)
        `CHK("default speed", `SET_SPEED_RESET, move_speed_o)
        b = $urandom_range(1, 500);
        wbx(1'b1, `OFF_ARG, b);
        cmd(32'h0000_000C);
        a = -$urandom_range(1, 1000000);
        wbx(1'b1, `OFF_ARG, a);
        cmd(32'h0000_000B);
        `CHK("reverse", 1'b1, move_reverse_o)
        `CHK("commanded speed", b, move_speed_o)
        cmd(32'h0000_0008);
        `CHK("halted", 1'b1, motion_halt_o)
        wbx(1'b1, `OFF_ARG, a + 32'h0000_0005);
        cmd(32'h0000_000B);
        `CHK("target kept", a, target_pos_o)
        `CHK("no start halted", 1'b0, pl[1])
        cmd(32'h0000_0007);
        `CHK("resumed", 1'b0, motion_halt_o)
        cmd(32'h0000_000B);
        `CHK("start after go", 1'b1, pl[1])
        cmd(32'h0000_000F);
        wbx(1'b0, `OFF_CUR_POS, 32'h0000_0000);
        `CHK("clear current", `POS_ZERO, rd)
        wbx(1'b0, `OFF_TGT_POS, 32'h0000_0000);
        `CHK("clear target", `POS_ZERO, rd)
        b = $urandom;
        stepit(b);
        wbx(1'b0, `OFF_CUR_POS, 32'h0000_0000);
        `CHK("current", b, rd)
        cmd(32'h0000_000E);
        wbx(1'b0, `OFF_TGT_POS, 32'h0000_0000);
        `CHK("adopt", b, rd)
        e = $urandom_range(1, 4000);
        stepit(e);
        wbx(1'b0, `OFF_POS_ERR, 32'h0000_0000);
        `CHK("error", -e, rd)
        cmd(32'h0000_0010);
        wbx(1'b0, `OFF_TGT_POS, 32'h0000_0000);
        `CHK("eclear target", `POS_ZERO, rd)
        wbx(1'b0, `OFF_POS_ERR, 32'h0000_0000);
        `CHK("eclear error", -e, rd)
        wbx(1'b0, `OFF_CUR_POS, 32'h0000_0000);
        `CHK("eclear current", e, rd)
        b = $urandom;
        wbx(1'b1, `OFF_ORIGIN_POS, b);
        cmd(32'h0000_000D);
        wbx(1'b0, `OFF_CUR_POS, 32'h0000_0000);
        `CHK("preset current", b, rd)
        wbx(1'b0, `OFF_TGT_POS, 32'h0000_0000);
        `CHK("preset target", b, rd)
        for (int i = 0; i < 4; i++) begin
            filtered_speed_i <= $urandom; origin_switch_i <= 1'($urandom);
            alarm_lines_i <= 3'($urandom); in_position_i <= 1'($urandom); alarm_pending_i <= i[0];
            wbx(1'b0, `OFF_SPEED_MON, 32'h0000_0000);
            `CHK("speed monitor", filtered_speed_i, rd)
            wbx(1'b0, `OFF_ORIGIN_SW, 32'h0000_0000);
            `CHK("origin switch", {31'h0000_0000, origin_switch_i}, rd)
            wbx(1'b0, `OFF_OUT_STATUS, 32'h0000_0000);
            `CHK("status", status_exp(1'b1, alarm_pending_i, in_position_i, alarm_lines_i), rd)
            cmd(32'h0000_0009);
            `CHK("alarm reset", {2{alarm_pending_i}}, pl[3:2])
        end
        cmd(32'h0000_000A);
        `CHK("restart", 1'b1, restart_o)
        n = 0;
        while (restart_o === 1'b1 && n < 100) begin @(posedge clk_i); n++; end
        `CHK("restart done", 1'b0, restart_o)
        `CHK("servo after restart", 1'b0, servo_enable_o)
        wbx(1'b0, `OFF_MASK, 32'h0000_0000);
        `CHK("mask after restart", 32'h0000_0000, rd)
        wbx(1'b0, 8'h3C, 32'h0000_0000);
        `CHK("unmapped", 32'h0000_0000, rd)
        results();
    end
endmodule : servo_command_interpreter_tb
